// ===== fsps_pkg.sv
// Constants for the sector protect and operation status block
package fsps_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [15:0] SECT_CTRL_ADDR = 16'h0073;
  localparam logic [15:0] STAT3_ADDR = 16'h0074;
  localparam logic [7:0] SECT_CTRL_RESET = 8'h00;
  localparam logic [7:0] STAT3_RESET = 8'h00;
  localparam int NUM_SECTORS = 6;
  localparam int SECT_FIVE = 5;
  localparam int SECT_FOUR = 4;
  localparam int SECT_ZERO = 0;
  // ----------------------------------------
  // Status three field positions
  // ----------------------------------------
  localparam int ST_ERASE_READ_PERIOD_FLAG_BIT = 4;
  localparam int ST_ERASE_SUSPENDED_FLAG_BIT = 3;
  localparam int ST_SECTOR_ERASE_ACTIVE_FLAG_BIT = 2;
  localparam int ST_PROGRAM_ACTIVE_FLAG_BIT = 1;
  localparam int ST_HANG_BIT = 0;
  // ----------------------------------------
  // Command delay line layout and timing
  // ----------------------------------------
  localparam int CMD_DELAY_CYCLES = 2;
  localparam int DL_PROGRAM = 0;
  localparam int DL_ERASE = 1;
  localparam int DL_SUSPEND = 2;
  localparam int DL_RESUME = 3;
  localparam int DL_RESET = 4;
  localparam int DL_ERASE_READ_PERIOD_FLAG = 5;
  localparam int DL_WIDTH = 6;
  localparam int CLOCK_PERIOD_NS = 25;
  localparam int PROGRAM_ACTIVE_FLAG_MIN_PERIOD_NS = 1000;
endpackage : fsps_pkg

// ===== fsps_delay.sv
// Fixed-depth delay line carrying command strobes and the erase-read level
`timescale 1ns/1ps
module fsps_delay #(
  parameter int WIDTH = fsps_pkg::DL_WIDTH,
  parameter int DEPTH = fsps_pkg::CMD_DELAY_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] din_i,
  output logic [WIDTH-1:0] dout_o
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] stage;
  } fsps_dl_state_t;

  fsps_dl_state_t s_q;
  fsps_dl_state_t s_d;

  initial begin
    if (DEPTH < 1 || WIDTH < 1) begin
      $error("fsps_delay: DEPTH and WIDTH must be at least one");
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.stage[0] = din_i;
    for (int i = 1; i < DEPTH; i++) begin
      s_d.stage[i] = s_q.stage[i-1];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout_o = s_q.stage[DEPTH-1];
endmodule : fsps_delay

// ===== fsps_top.sv
// Sector write protect and flash operation status three register
`timescale 1ns/1ps
// Function
// - Six sector enables bit5..bit0, reset cleared
// - Writing one unlocks program/erase for sector
// - Writing zero locks sector until reset
// - Only reset clears the sector lock
// - Global enable low blocks every flash write
// - Bit4 mirrors erase read period signal
// - Erase read period rises two cycles later
// - Bit3 shows erase suspended, two-cycle rise
// - Bit2 shows sector erase active, two-cycle rise
// - Bit1 shows programming active, two-cycle rise
// - Programming bit never set below 1 us period
// - Bit0 hang flag, cleared two cycles after reset command
// - Status bits 7:5 read zero, ignore writes
// - Swap active output copies swap enable one cycle later
// - Chip erase needs every sector enabled
module fsps_top #(
  parameter int CLK_PERIOD_NS = fsps_pkg::CLOCK_PERIOD_NS,
  parameter int DELAY_CYCLES = fsps_pkg::CMD_DELAY_CYCLES
) (
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  input wire logic [15:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] WDATA_I,
  input wire logic GLOBAL_ENABLE_I,
  input wire logic SWAP_ENABLE_I,
  input wire logic [2:0] TARGET_SECTOR_I,
  input wire logic CMD_PROGRAM_I,
  input wire logic CMD_SECTOR_ERASE_I,
  input wire logic CMD_CHIP_ERASE_I,
  input wire logic CMD_SUSPEND_I,
  input wire logic CMD_RESUME_I,
  input wire logic CMD_RESET_I,
  input wire logic ERASE_READ_PERIOD_I,
  input wire logic PROGRAM_DONE_I,
  input wire logic ERASE_DONE_I,
  input wire logic HANG_EVENT_I,
  output logic [7:0] RDATA_O,
  output logic [5:0] SECTOR_WRITE_OK_O,
  output logic FLASH_WRITE_O,
  output logic CHIP_ERASE_ACCEPT_O,
  output logic SWAP_ACTIVE_O
);
  localparam int NS = fsps_pkg::NUM_SECTORS;
  localparam bit PROGRAM_ACTIVE_FLAG_USABLE = (CLK_PERIOD_NS >= fsps_pkg::PROGRAM_ACTIVE_FLAG_MIN_PERIOD_NS);

  initial begin
    if (DELAY_CYCLES < 2 || CLK_PERIOD_NS < 1) begin
      $error("fsps_top: delay must be at least two and clock period positive");
    end
    if (NS != 6) begin
      $error("fsps_top: sector count must match the six-bit ports");
    end
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [NS-1:0] enable;
    logic [NS-1:0] lock;
    logic erase_read_period_flag;
    logic erase_suspended_flag;
    logic sector_erase_active_flag;
    logic program_active_flag;
    logic hang;
    logic [7:0] rdata;
    logic [NS-1:0] write_ok;
    logic flash_write;
    logic chip_accept;
    logic swap;
  } fsps_state_t;

  fsps_state_t s_q;
  fsps_state_t s_d;
  logic [fsps_pkg::DL_WIDTH-1:0] dl_in;
  logic [fsps_pkg::DL_WIDTH-1:0] dl_out;

  // Write permission for one sector, used for commands and for the output vector
  function automatic logic sector_ok(input logic [NS-1:0] en, input logic [NS-1:0] lk,
                                     input logic glob, input int idx);
    sector_ok = glob & en[idx] & ~lk[idx];
  endfunction : sector_ok

  // Register address decode, shared by the write and read paths
  function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] reg_a);
    addr_hit = (a == reg_a);
  endfunction : addr_hit

  // ----------------------------------------
  // Command delay
  // ----------------------------------------
  logic tgt_ok;
  logic all_ok;

  always_comb begin
    tgt_ok = 1'b0;
    all_ok = GLOBAL_ENABLE_I;
    for (int i = 0; i < NS; i++) begin
      if (TARGET_SECTOR_I == 3'(i)) begin
        tgt_ok = sector_ok(s_q.enable, s_q.lock, GLOBAL_ENABLE_I, i);
      end
      all_ok = all_ok & sector_ok(s_q.enable, s_q.lock, GLOBAL_ENABLE_I, i);
    end
  end

  // Program and erase commands are qualified before the delay so a later unlock cannot revive them
  always_comb begin
    dl_in = '0;
    dl_in[fsps_pkg::DL_PROGRAM] = CMD_PROGRAM_I & tgt_ok;
    dl_in[fsps_pkg::DL_ERASE] = CMD_SECTOR_ERASE_I & tgt_ok;
    dl_in[fsps_pkg::DL_SUSPEND] = CMD_SUSPEND_I;
    dl_in[fsps_pkg::DL_RESUME] = CMD_RESUME_I;
    dl_in[fsps_pkg::DL_RESET] = CMD_RESET_I;
    dl_in[fsps_pkg::DL_ERASE_READ_PERIOD_FLAG] = ERASE_READ_PERIOD_I;
  end

  fsps_delay #(
    .WIDTH(fsps_pkg::DL_WIDTH),
    .DEPTH(DELAY_CYCLES - 1)
  ) u_delay (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .din_i(dl_in),
    .dout_o(dl_out)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic wr_ctrl;

  always_comb begin
    s_d = s_q;
    wr_ctrl = WR_I && addr_hit(ADDR_I, fsps_pkg::SECT_CTRL_ADDR);
    // Lock is sticky; a one written later to a locked bit is dropped
    // Bits 7:6 are not stored, so they read back as zero
    if (wr_ctrl) begin
      for (int i = 0; i < NS; i++) begin
        if (!WDATA_I[i]) begin
          s_d.lock[i] = 1'b1;
        end
        s_d.enable[i] = WDATA_I[i] & ~s_d.lock[i];
      end
    end
    // Status flags follow the two-cycle command delay, except done and hang event inputs, which act after one cycle
    s_d.erase_read_period_flag = dl_out[fsps_pkg::DL_ERASE_READ_PERIOD_FLAG];
    if (dl_out[fsps_pkg::DL_RESUME] || dl_out[fsps_pkg::DL_RESET] || !s_q.sector_erase_active_flag) begin
      s_d.erase_suspended_flag = 1'b0;
    end
    if (dl_out[fsps_pkg::DL_SUSPEND] && s_q.sector_erase_active_flag) begin
      s_d.erase_suspended_flag = 1'b1;
    end
    if (ERASE_DONE_I || dl_out[fsps_pkg::DL_RESET]) begin
      s_d.sector_erase_active_flag = 1'b0;
    end
    if (dl_out[fsps_pkg::DL_ERASE]) begin
      s_d.sector_erase_active_flag = 1'b1;
    end
    if (PROGRAM_DONE_I || dl_out[fsps_pkg::DL_RESET]) begin
      s_d.program_active_flag = 1'b0;
    end
    // Fast clocks never see the program flag rise
    if (dl_out[fsps_pkg::DL_PROGRAM] && PROGRAM_ACTIVE_FLAG_USABLE) begin
      s_d.program_active_flag = 1'b1;
    end
    if (dl_out[fsps_pkg::DL_RESET]) begin
      s_d.hang = 1'b0;
    end
    if (HANG_EVENT_I) begin
      s_d.hang = 1'b1;
    end
    // Read data registered one cycle after the strobe
    s_d.rdata = 8'h00;
    if (RD_I && addr_hit(ADDR_I, fsps_pkg::SECT_CTRL_ADDR)) begin
      s_d.rdata[NS-1:0] = s_q.enable;
    end else if (RD_I && addr_hit(ADDR_I, fsps_pkg::STAT3_ADDR)) begin
      s_d.rdata[fsps_pkg::ST_ERASE_READ_PERIOD_FLAG_BIT] = s_q.erase_read_period_flag;
      s_d.rdata[fsps_pkg::ST_ERASE_SUSPENDED_FLAG_BIT] = s_q.erase_suspended_flag;
      s_d.rdata[fsps_pkg::ST_SECTOR_ERASE_ACTIVE_FLAG_BIT] = s_q.sector_erase_active_flag;
      s_d.rdata[fsps_pkg::ST_PROGRAM_ACTIVE_FLAG_BIT] = s_q.program_active_flag;
      s_d.rdata[fsps_pkg::ST_HANG_BIT] = s_q.hang;
    end
    for (int i = 0; i < NS; i++) begin
      s_d.write_ok[i] = sector_ok(s_q.enable, s_q.lock, GLOBAL_ENABLE_I, i);
    end
    s_d.flash_write = (CMD_PROGRAM_I | CMD_SECTOR_ERASE_I) & tgt_ok;
    s_d.chip_accept = CMD_CHIP_ERASE_I & all_ok;
    s_d.swap = SWAP_ENABLE_I;
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // All outputs leave straight from the state register, no logic after it
  assign RDATA_O = s_q.rdata;
  assign SECTOR_WRITE_OK_O = s_q.write_ok;
  assign FLASH_WRITE_O = s_q.flash_write;
  assign CHIP_ERASE_ACCEPT_O = s_q.chip_accept;
  assign SWAP_ACTIVE_O = s_q.swap;
endmodule : fsps_top

// ===== fsps_assertions.sv
// Port checker for the sector protect block
`timescale 1ns/1ps
module fsps_assertions (
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  input wire logic [15:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] WDATA_I,
  input wire logic GLOBAL_ENABLE_I,
  input wire logic SWAP_ENABLE_I,
  input wire logic CMD_CHIP_ERASE_I,
  input wire logic [7:0] RDATA_O,
  input wire logic [5:0] SECTOR_WRITE_OK_O,
  input wire logic FLASH_WRITE_O,
  input wire logic CHIP_ERASE_ACCEPT_O,
  input wire logic SWAP_ACTIVE_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);
  sequence s_lock0;
    WR_I && ADDR_I == 16'h0073 && !WDATA_I[0];
  endsequence
  a_read_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("stray rdata");
  a_ctrl_resv: assert property ($past(RD_I && ADDR_I == 16'h0073) |-> !RDATA_O[7:6])
    else $error("ctrl 7:6");
  a_stat_resv: assert property ($past(RD_I && ADDR_I == 16'h0074) |-> !RDATA_O[7:5])
    else $error("stat 7:5");
  a_glob_gate: assert property (!$past(GLOBAL_ENABLE_I) |-> !SECTOR_WRITE_OK_O)
    else $error("ok no global");
  a_write_gate: assert property (FLASH_WRITE_O |-> $past(GLOBAL_ENABLE_I))
    else $error("write no global");
  a_chip_gate: assert property (CHIP_ERASE_ACCEPT_O |->
    $past(CMD_CHIP_ERASE_I && GLOBAL_ENABLE_I) && &SECTOR_WRITE_OK_O) else $error("chip");
  a_swap_copy: assert property (SWAP_ACTIVE_O == $past(SWAP_ENABLE_I))
    else $error("swap");
  a_lock_hold: assert property (s_lock0 |=> ##1 (!SECTOR_WRITE_OK_O[0]) [*8])
    else $error("lock");
endmodule : fsps_assertions
bind fsps_top fsps_assertions i_chk (.CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .ADDR_I(ADDR_I),
  .WR_I(WR_I), .RD_I(RD_I), .WDATA_I(WDATA_I), .GLOBAL_ENABLE_I(GLOBAL_ENABLE_I),
  .SWAP_ENABLE_I(SWAP_ENABLE_I), .CMD_CHIP_ERASE_I(CMD_CHIP_ERASE_I), .RDATA_O(RDATA_O),
  .SECTOR_WRITE_OK_O(SECTOR_WRITE_OK_O), .FLASH_WRITE_O(FLASH_WRITE_O),
  .CHIP_ERASE_ACCEPT_O(CHIP_ERASE_ACCEPT_O), .SWAP_ACTIVE_O(SWAP_ACTIVE_O));

// ===== fsps_flash_model.sv
// Flash array model with a busy span
`timescale 1ns/1ps
module fsps_flash_model #(parameter int BUSY = 20) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic erase_read_period_flag_o,
  output logic done_o
);
  int cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i) cnt <= 0;
    else if (start_i) cnt <= BUSY;
    else if (cnt != 0) cnt <= cnt - 1;
  end
  // Erase read period held through the busy span except its last (done) cycle
  assign erase_read_period_flag_o = cnt > 1;
  assign done_o = cnt == 1;
endmodule : fsps_flash_model

// ===== test_flash_sector_protect_status.sv
// Bench for the sector protect block
`timescale 1ns/1ps
module test_flash_sector_protect_status;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, glob = 1'b0, swap = 1'b0;
  logic fw, ca, sa, erase_read_period_flag, done;
  logic [15:0] addr = 16'h0000, ct = 16'h0073, st = 16'h0074;
  logic [7:0] wd = 8'h00, rdata;
  logic [7:0] rdata_slow;
  logic [6:0] cv = 7'h00;
  logic [5:0] ok;
  logic [2:0] tgt = 3'h0;
  int n_mismatch = 0, check_count = 0;
  always #12.5 clk = ~clk;
  fsps_top i_dut (.CLOCK_I(clk), .RESET_I(rst), .ADDR_I(addr), .WR_I(wr), .RD_I(rd),
    .WDATA_I(wd), .GLOBAL_ENABLE_I(glob), .SWAP_ENABLE_I(swap), .TARGET_SECTOR_I(tgt),
    .CMD_PROGRAM_I(cv[0]), .CMD_SECTOR_ERASE_I(cv[1]), .CMD_CHIP_ERASE_I(cv[2]),
    .CMD_SUSPEND_I(cv[3]), .CMD_RESUME_I(cv[4]), .CMD_RESET_I(cv[5]), .HANG_EVENT_I(cv[6]),
    .ERASE_READ_PERIOD_I(erase_read_period_flag), .PROGRAM_DONE_I(done), .ERASE_DONE_I(done),
    .RDATA_O(rdata), .SECTOR_WRITE_OK_O(ok), .FLASH_WRITE_O(fw),
    .CHIP_ERASE_ACCEPT_O(ca), .SWAP_ACTIVE_O(sa));
  fsps_flash_model i_arr (.clk_i(clk), .rst_i(rst), .start_i(fw), .erase_read_period_flag_o(erase_read_period_flag), .done_o(done));
  // Copy with CLK_PERIOD_NS set to 1000 on the same clock so the programming flag can rise at all
  fsps_top #(.CLK_PERIOD_NS(1000)) i_dut_slow (.CLOCK_I(clk), .RESET_I(rst), .ADDR_I(addr),
    .WR_I(wr), .RD_I(rd), .WDATA_I(wd), .GLOBAL_ENABLE_I(glob), .SWAP_ENABLE_I(swap),
    .TARGET_SECTOR_I(tgt), .CMD_PROGRAM_I(cv[0]), .CMD_SECTOR_ERASE_I(cv[1]),
    .CMD_CHIP_ERASE_I(cv[2]), .CMD_SUSPEND_I(cv[3]), .CMD_RESUME_I(cv[4]),
    .CMD_RESET_I(cv[5]), .HANG_EVENT_I(cv[6]), .ERASE_READ_PERIOD_I(erase_read_period_flag),
    .PROGRAM_DONE_I(done), .ERASE_DONE_I(done), .RDATA_O(rdata_slow),
    .SECTOR_WRITE_OK_O(), .FLASH_WRITE_O(), .CHIP_ERASE_ACCEPT_O(), .SWAP_ACTIVE_O());
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %0t %h %h", $time, g, e);
    end
  endtask : chk
  task automatic acc(input int w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= w[0];
    rd <= !w[0];
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    if (w == 0) chk(rdata, d);
  endtask : acc
  task automatic cmd(input int b, input int s);
    @(posedge clk);
    cv <= 7'h01 << b;
    tgt <= s[2:0];
    @(posedge clk);
    cv <= 7'h00;
    #1;
  endtask : cmd
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    acc(0, ct, 8'h00);
    acc(0, st, 8'h00);
    @(posedge clk) glob <= 1'b1;
    acc(1, ct, 8'h3F);
    acc(0, ct, 8'h3F);
    chk({2'h0, ok}, 8'h3F);
    cmd(2, 0);
    chk({7'h0, ca}, 8'h01);
    cmd(1, 2);
    chk({7'h0, fw}, 8'h01);
    acc(0, st, 8'h04);
    acc(0, st, 8'h14);
    cmd(3, 2);
    acc(0, st, 8'h1C);
    cmd(4, 2);
    acc(0, st, 8'h14);
    repeat (25) @(posedge clk);
    acc(0, st, 8'h00);
    cmd(0, 1);
    chk({7'h0, fw}, 8'h01);
    acc(0, st, 8'h00);
    chk(rdata_slow, 8'h02);
    repeat (25) @(posedge clk);
    cmd(6, 0);
    acc(0, st, 8'h01);
    chk(rdata_slow, 8'h01);
    cmd(5, 0);
    acc(0, st, 8'h00);
    acc(1, ct, 8'h3E);
    acc(1, ct, 8'h3F);
    acc(0, ct, 8'h3E);
    chk({2'h0, ok}, 8'h3E);
    cmd(1, 0);
    chk({7'h0, fw}, 8'h00);
    cmd(2, 0);
    chk({7'h0, ca}, 8'h00);
    @(posedge clk) glob <= 1'b0;
    cmd(1, 1);
    chk({7'h0, fw}, 8'h00);
    chk({2'h0, ok}, 8'h00);
    acc(1, st, 8'h7F);
    acc(0, st, 8'h00);
    acc(0, 16'h0075, 8'h00);
    @(posedge clk) swap <= 1'b1;
    @(posedge clk) swap <= 1'b0;
    #1 chk({7'h0, sa}, 8'h01);
    @(posedge clk) rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    glob <= 1'b1;
    acc(1, ct, 8'h3F);
    acc(0, ct, 8'h3F);
    chk({2'h0, ok}, 8'h3F);
    conclude();
  end
endmodule : test_flash_sector_protect_status
